// file: rtl/brs_pkg.sv
`default_nettype none
package brs_pkg;
    // Debounce time and derived cycle count at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int DEBOUNCE_US = 1000;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int SYNC_STAGES = 2;
    // Route selection: which input drives the program bus
    typedef enum logic [1:0] {
        ROUTE_IN1 = 2'b01,
        ROUTE_IN2 = 2'b10
    } brs_route_t;
    localparam brs_route_t ROUTE_RESET = ROUTE_IN1;
    // Video standard sensed on the input
    localparam logic STD_SD = 1'b0;
    localparam logic STD_HD = 1'b1;
    // Reference type codes
    localparam logic [1:0] REF_NONE = 2'h0;
    localparam logic [1:0] REF_BLACK_525 = 2'h1;
    localparam logic [1:0] REF_BLACK_625 = 2'h2;
    localparam logic [1:0] REF_TRILEVEL = 2'h3;
endpackage
`default_nettype wire

// file: rtl/brs_gpi_if.sv
`default_nettype none
interface brs_gpi_if;
    logic [1:0] fall;
    logic [1:0] level_low;
    modport src (output fall, output level_low);
    modport dst (input fall, input level_low);
endinterface
`default_nettype wire

// file: rtl/brs_gpi_filter.sv
`default_nettype none
module brs_gpi_filter #(
    parameter int DEB_CYC = 100000
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic srst,
    input wire logic [1:0] gpi_n,
    brs_gpi_if.src gp
);
    import brs_pkg::*;
    localparam int CW = $clog2(DEB_CYC + 1);
    initial begin
        if (DEB_CYC < 1) $error("DEB_CYC must be at least 1");
    end
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] stable_reg;
    logic [1:0] fall_reg;
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            logic [CW-1:0] cnt_reg;
            wire differs = s2_reg[i] != stable_reg[i];
            wire done = cnt_reg == CW'(DEB_CYC - 1);
            always_ff @(posedge clk) begin
                if (srst) begin
                    // Pull-up idle level: inactive
                    s1_reg[i] <= 1'b1;
                    s2_reg[i] <= 1'b1;
                    stable_reg[i] <= 1'b1;
                    fall_reg[i] <= 1'b0;
                    cnt_reg <= '0;
                end else if (ce) begin
                    s1_reg[i] <= gpi_n[i];
                    s2_reg[i] <= s1_reg[i];
                    fall_reg[i] <= 1'b0;
                    if (!differs) begin
                        cnt_reg <= '0;
                    end else if (done) begin
                        cnt_reg <= '0;
                        stable_reg[i] <= s2_reg[i];
                        fall_reg[i] <= ~s2_reg[i];
                    end else begin
                        cnt_reg <= cnt_reg + CW'(1);
                    end
                end
            end
        end
    endgenerate
    assign gp.fall = fall_reg;
    assign gp.level_low = ~stable_reg;
endmodule
`default_nettype wire

// file: rtl/brs_select.sv
`default_nettype none
module brs_select
    import brs_pkg::*;
#(
    parameter int DEB_CYC = DEBOUNCE_CYC
) (
    input wire logic CLK,
    input wire logic CE,
    input wire logic SRST,
    input wire logic [1:0] GPI_N,
    input wire logic AUTO_MODE,
    input wire logic AUTO_SEL_IN2,
    input wire logic IN1_HD,
    input wire logic REF_PRESENT,
    input wire logic REF_TRILEVEL_DET,
    input wire logic REF_625_DET,
    input wire logic POWER_GOOD,
    output logic PGM_SEL_IN2,
    output logic PRV_SEL_IN2,
    output logic [1:0] TALLY,
    output logic [1:0] TALLY_OE_N,
    output logic BYPASS_RELAY_ON,
    output logic MON_DOWNCONV_EN,
    output logic MON_AUDIO_EN,
    output logic [1:0] MON_AUDIO_GROUPS,
    output logic PGM_STD_HD,
    output logic [1:0] REF_TYPE
);
    import brs_pkg::*;
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    initial begin
        if (DEB_CYC < 1) $error("DEB_CYC must be at least 1");
        // The status synchronizers below are written out for two stages
        if (SYNC_STAGES != 2) $error("SYNC_STAGES must be 2");
        // Tally and selects decode the route as one-hot
        if ($countones(ROUTE_IN1) != 1 || $countones(ROUTE_IN2) != 1) begin
            $error("route codes must be one-hot");
        end
        if (ROUTE_IN1 == ROUTE_IN2) $error("route codes must differ");
    end

    // ----------------------------------------------------------------
    // Contact inputs
    // ----------------------------------------------------------------
    brs_gpi_if gp();
    brs_gpi_filter #(.DEB_CYC(DEB_CYC)) u_filt (
        .clk(CLK),
        .ce(CE),
        .srst(SRST),
        .gpi_n(GPI_N),
        .gp(gp)
    );

    // ----------------------------------------------------------------
    // Route decision
    // ----------------------------------------------------------------
    brs_route_t route_reg;
    brs_route_t route_next;
    logic pwr_s1_reg;
    logic pwr_s2_reg;
    logic std_s1_reg;
    logic std_s2_reg;
    logic [1:0] ref_s1_reg;
    logic [1:0] ref_s2_reg;
    logic ref_p1_reg;
    logic ref_p2_reg;
    logic auto_s1_reg;
    logic auto_s2_reg;

    // One-sided level forces the route in auto mode
    wire only1 = gp.level_low == 2'b01;
    wire only2 = gp.level_low == 2'b10;
    wire auto_route2 = only2 ? 1'b1 : (only1 ? 1'b0 : auto_s2_reg);

    always_comb begin
        route_next = route_reg;
        if (AUTO_MODE) begin
            // Forced or automatic decision
            route_next = auto_route2 ? ROUTE_IN2 : ROUTE_IN1;
        end else if (gp.fall[0]) begin
            // A tie between closures goes to input one
            route_next = ROUTE_IN1;
        end else if (gp.fall[1]) begin
            route_next = ROUTE_IN2;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            route_reg <= ROUTE_RESET;
        end else if (CE) begin
            // Input skew is absorbed upstream, so any enabled edge may switch
            route_reg <= route_next;
        end
    end

    // ----------------------------------------------------------------
    // Status synchronizers
    // ----------------------------------------------------------------
    // Power-good starts low so the relay holds bypass until it is seen
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pwr_s1_reg <= 1'b0;
            pwr_s2_reg <= 1'b0;
        end else if (CE) begin
            pwr_s1_reg <= POWER_GOOD;
            pwr_s2_reg <= pwr_s1_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            std_s1_reg <= STD_SD;
            std_s2_reg <= STD_SD;
        end else if (CE) begin
            std_s1_reg <= IN1_HD;
            std_s2_reg <= std_s1_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ref_s1_reg <= 2'h0;
            ref_s2_reg <= 2'h0;
            ref_p1_reg <= 1'b0;
            ref_p2_reg <= 1'b0;
        end else if (CE) begin
            ref_s1_reg <= {REF_TRILEVEL_DET, REF_625_DET};
            ref_s2_reg <= ref_s1_reg;
            ref_p1_reg <= REF_PRESENT;
            ref_p2_reg <= ref_p1_reg;
        end
    end

    // The auto decision comes from slower logic and is resynchronized
    always_ff @(posedge CLK) begin
        if (SRST) begin
            auto_s1_reg <= 1'b0;
            auto_s2_reg <= 1'b0;
        end else if (CE) begin
            auto_s1_reg <= AUTO_SEL_IN2;
            auto_s2_reg <= auto_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic [1:0] tally_reg;
    logic bypass_reg;
    logic std_reg;
    logic [1:0] ref_reg;

    wire is_in2 = route_reg == ROUTE_IN2;
    wire [1:0] ref_dec = !ref_p2_reg ? REF_NONE :
                         ref_s2_reg[1] ? REF_TRILEVEL :
                         ref_s2_reg[0] ? REF_BLACK_625 : REF_BLACK_525;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tally_reg <= 2'b00;
        end else if (CE) begin
            tally_reg <= {is_in2, ~is_in2};
        end
    end

    // Relay defaults to bypass so a dead card keeps program up
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bypass_reg <= 1'b1;
        end else if (CE) begin
            bypass_reg <= ~pwr_s2_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            std_reg <= STD_SD;
        end else if (CE) begin
            std_reg <= std_s2_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ref_reg <= REF_NONE;
        end else if (CE) begin
            ref_reg <= ref_dec;
        end
    end

    assign PGM_SEL_IN2 = is_in2;
    assign PRV_SEL_IN2 = ~is_in2;
    assign TALLY = tally_reg;
    // Open collector: enable low while driving low, released when high
    assign TALLY_OE_N = tally_reg;
    assign BYPASS_RELAY_ON = bypass_reg;
    // Program follows the input standard; the monitor downconverts when the input is HD
    assign PGM_STD_HD = std_reg;
    assign MON_DOWNCONV_EN = std_reg;
    assign MON_AUDIO_EN = 1'b1;
    assign MON_AUDIO_GROUPS = 2'b11;
    assign REF_TYPE = ref_reg;
endmodule
`default_nettype wire

// file: verif/brs_select_monitor.sv
`default_nettype none
module brs_select_monitor
    import brs_pkg::*;
(
    input wire logic CLK,
    input wire logic CE,
    input wire logic SRST,
    input wire logic [1:0] GPI_N,
    input wire logic AUTO_MODE,
    input wire logic AUTO_SEL_IN2,
    input wire logic IN1_HD,
    input wire logic REF_PRESENT,
    input wire logic REF_TRILEVEL_DET,
    input wire logic POWER_GOOD,
    input wire logic PGM_SEL_IN2,
    input wire logic [1:0] TALLY,
    input wire logic [1:0] TALLY_OE_N,
    input wire logic BYPASS_RELAY_ON,
    input wire logic MON_DOWNCONV_EN,
    input wire logic PGM_STD_HD,
    input wire logic [1:0] REF_TYPE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK);
    endclocking
    // A frozen clock enable holds all state, so nothing is judged then
    default disable iff (SRST || !CE);
    sequence s_man1;
        $fell(GPI_N[0]) && GPI_N[1] ##1 (!AUTO_MODE && GPI_N == 2'h2)[*8];
    endsequence
    sequence s_man2;
        $fell(GPI_N[1]) && GPI_N[0] ##1 (!AUTO_MODE && GPI_N == 2'h1)[*8];
    endsequence
    property p_rst;
        disable iff (1'b0) SRST && CE |=> !PGM_SEL_IN2 && TALLY == 2'h0
            && BYPASS_RELAY_ON && REF_TYPE == REF_NONE;
    endproperty
    property p_tal;
        !$past(SRST) |-> TALLY_OE_N == TALLY
            && TALLY == {$past(PGM_SEL_IN2), !$past(PGM_SEL_IN2)};
    endproperty
    property p_std;
        $stable(IN1_HD)[*5] |-> PGM_STD_HD == IN1_HD
            && MON_DOWNCONV_EN == IN1_HD;
    endproperty
    property p_byp;
        $stable(POWER_GOOD)[*5] |-> BYPASS_RELAY_ON == !POWER_GOOD;
    endproperty
    property p_ref;
        (REF_PRESENT && REF_TRILEVEL_DET)[*5] |-> REF_TYPE == REF_TRILEVEL;
    endproperty
    property p_man1;
        s_man1 |-> ##2 !PGM_SEL_IN2;
    endproperty
    property p_man2;
        s_man2 |-> ##2 PGM_SEL_IN2;
    endproperty
    property p_force;
        (AUTO_MODE && GPI_N == 2'h1)[*8] |-> ##2 PGM_SEL_IN2;
    endproperty
    property p_keep;
        (AUTO_MODE && GPI_N[0] == GPI_N[1])[*8] |=>
            PGM_SEL_IN2 == $past(AUTO_SEL_IN2, 3);
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    a_tal: assert property (p_tal) else $error("tally");
    a_std: assert property (p_std) else $error("std");
    a_byp: assert property (p_byp) else $error("bypass");
    a_ref: assert property (p_ref) else $error("ref");
    a_man1: assert property (p_man1) else $error("man1");
    a_man2: assert property (p_man2) else $error("man2");
    a_force: assert property (p_force) else $error("force");
    a_keep: assert property (p_keep) else $error("keep");
endmodule
bind brs_select brs_select_monitor u_mon (.CLK(CLK), .CE(CE), .SRST(SRST),
    .GPI_N(GPI_N), .AUTO_MODE(AUTO_MODE), .AUTO_SEL_IN2(AUTO_SEL_IN2),
    .IN1_HD(IN1_HD), .REF_PRESENT(REF_PRESENT), .POWER_GOOD(POWER_GOOD),
    .REF_TRILEVEL_DET(REF_TRILEVEL_DET), .PGM_SEL_IN2(PGM_SEL_IN2),
    .TALLY(TALLY), .TALLY_OE_N(TALLY_OE_N), .REF_TYPE(REF_TYPE),
    .BYPASS_RELAY_ON(BYPASS_RELAY_ON), .MON_DOWNCONV_EN(MON_DOWNCONV_EN),
    .PGM_STD_HD(PGM_STD_HD));
`default_nettype wire

// file: verif/brs_contact_model.sv
`default_nettype none
module brs_contact_model (
    input wire logic [1:0] close,
    input wire logic [1:0] oe_n,
    output logic [1:0] gpi_n,
    output logic [1:0] tally_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Open contacts float up to the pull-up level
    assign gpi_n = ~close;
    // Open collector: pulled low only while enabled, else pulled up
    assign tally_pin = oe_n;
endmodule
`default_nettype wire

// file: verif/test_bypass_router_select_control.sv
`default_nettype none
module test_bypass_router_select_control;
    timeunit 1ns;
    timeprecision 1ns;
    import brs_pkg::*;
    logic clk = 1'b0, srst = 1'b1, auto = 1'b0, asel = 1'b0, hd = 1'b0;
    logic rp = 1'b0, rt = 1'b0, pg = 1'b1, ce = 1'b1, r625 = 1'b0;
    logic [1:0] close = 2'h0;
    wire logic [1:0] gpi_n, tp, tally, oe_n, agr, rtype;
    wire logic pgm, prv, byp, dce, aen, std;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    brs_contact_model u_far (.close(close), .oe_n(oe_n), .gpi_n(gpi_n),
        .tally_pin(tp));
    brs_select #(.DEB_CYC(4)) dut (.CLK(clk), .CE(ce), .SRST(srst),
        .GPI_N(gpi_n), .AUTO_MODE(auto), .AUTO_SEL_IN2(asel), .IN1_HD(hd),
        .REF_PRESENT(rp), .REF_TRILEVEL_DET(rt), .REF_625_DET(r625),
        .POWER_GOOD(pg), .PGM_SEL_IN2(pgm), .PRV_SEL_IN2(prv),
        .TALLY(tally), .TALLY_OE_N(oe_n), .BYPASS_RELAY_ON(byp),
        .MON_DOWNCONV_EN(dce), .MON_AUDIO_EN(aen), .MON_AUDIO_GROUPS(agr),
        .PGM_STD_HD(std), .REF_TYPE(rtype));
    initial forever #5 clk = ~clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Timeout is generous: the whole sequence needs about 200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input logic [1:0] g, input logic [1:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic press(input logic [1:0] c, input int n);
        close <= c;
        repeat (n) @(posedge clk);
        close <= 2'h0;
        repeat (12) @(posedge clk);
    endtask
    task automatic t_manual();
        press(2'h2, 10);
        chk({pgm, prv}, 2'h2);
        chk(tp, 2'h2);
        press(2'h1, 2);
        chk(tally, 2'h2);
        press(2'h1, 10);
        chk({pgm, prv}, 2'h1);
        chk(tp, 2'h1);
        $display("manual done");
    endtask
    task automatic t_freeze();
        ce <= 1'b0;
        press(2'h2, 10);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        chk(tally, 2'h1);
        $display("freeze done");
    endtask
    task automatic t_auto();
        auto <= 1'b1;
        asel <= 1'b1;
        repeat (12) @(posedge clk);
        chk(tally, 2'h2);
        close <= 2'h1;
        repeat (12) @(posedge clk);
        chk(tally, 2'h1);
        close <= 2'h3;
        repeat (12) @(posedge clk);
        chk(tally, 2'h2);
        asel <= 1'b0;
        close <= 2'h2;
        repeat (12) @(posedge clk);
        chk(tally, 2'h2);
        close <= 2'h3;
        repeat (12) @(posedge clk);
        chk(tally, 2'h1);
        $display("auto done");
    endtask
    task automatic t_status(input logic v);
        pg <= !v;
        hd <= v;
        rp <= v;
        rt <= v;
        repeat (8) @(posedge clk);
        chk({1'b0, byp}, {1'b0, v});
        chk({std, dce}, {v, v});
        chk(rtype, v ? REF_TRILEVEL : REF_NONE);
        chk({1'b0, aen}, 2'h1);
        chk(agr, 2'h3);
        $display("status done");
    endtask
    task automatic t_ref(input logic b625, input logic [1:0] e);
        rp <= 1'b1;
        rt <= 1'b0;
        r625 <= b625;
        repeat (8) @(posedge clk);
        chk(rtype, e);
        $display("reference done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(tally, 2'h1);
        t_manual();
        t_freeze();
        t_auto();
        t_status(1'b1);
        t_status(1'b0);
        t_ref(1'b1, REF_BLACK_625);
        t_ref(1'b0, REF_BLACK_525);
        summarize();
    end
endmodule
`default_nettype wire
